// ---- ccpu_defines.svh ----
// Register offsets, field positions, reset values and mode codes
`ifndef CCPU_DEFINES_SVH
`define CCPU_DEFINES_SVH
`define CCPU_A_UNIT_HI   5'h00
`define CCPU_R_CTRL      2'h0
`define CCPU_R_CAPSEL    2'h1
`define CCPU_R_DATA_LO   2'h2
`define CCPU_R_DATA_HI   2'h3
`define CCPU_A_TMRSEL    8'h08
`define CCPU_A_FLAGS     8'h09
`define CCPU_A_ODRAIN    8'h0A
`define CCPU_B_EN        7
`define CCPU_B_OUT       5
`define CCPU_B_ALIGN     4
`define CCPU_CTRL_WMASK  8'h9F
`define CCPU_TMRSEL_RST  8'h55
`define CCPU_M_OFF       4'h0
`define CCPU_M_TGL_CLR   4'h1
`define CCPU_M_TGL       4'h2
`define CCPU_M_CAP_ANY   4'h3
`define CCPU_M_CAP_FALL  4'h4
`define CCPU_M_CAP_RISE  4'h5
`define CCPU_M_CAP_4     4'h6
`define CCPU_M_CAP_16    4'h7
`define CCPU_M_SET       4'h8
`define CCPU_M_CLR       4'h9
`define CCPU_M_PLS       4'hA
`define CCPU_M_PLS_CLR   4'hB
`define CCPU_PRE_4_LAST  4'h3
`define CCPU_PRE_16_LAST 4'hF
`define CCPU_SRC_PIN     2'h0
`define CCPU_SRC_CMPA    2'h1
`define CCPU_SRC_CMPB    2'h2
`define CCPU_SRC_IOC     2'h3
`endif

// ---- ccpu_pkg.sv ----
// Types shared by the capture/compare/PWM block
package ccpu_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccpu_bus_req_t;

  typedef struct packed {
    logic level;
    logic oe;
  } ccpu_pin_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] capsel;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
    logic       out;
    logic       irq;
    logic       odrain;
    logic [3:0] pre_cnt;
    logic       pin_s1;
    logic       pin_s2;
    logic       src_prev;
    logic       match_prev;
    ccpu_pin_t  pin;
    logic [9:0] width;
  } ccpu_unit_t;

  typedef struct packed {
    ccpu_unit_t [1:0] unit;
    logic [7:0]       tmrsel;
    logic             cmpa_s1;
    logic             cmpa_s2;
    logic             cmpb_s1;
    logic             cmpb_s2;
    logic [2:0]       tclr;
    logic [7:0]       rdata;
  } ccpu_state_t;
endpackage : ccpu_pkg

// ---- ccpu_top.sv ----
// Two capture/compare/PWM units with register port and timer selection
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_defines.svh"

module ccpu_top (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire ccpu_pkg::ccpu_bus_req_t bus_req,
  output var  logic [7:0]             bus_rdata,
  input  wire logic [15:0]            timer_one_count,
  input  wire logic [15:0]            timer_three_count,
  input  wire logic [15:0]            timer_five_count,
  input  wire logic                   unit1_input_pin_map,
  input  wire logic                   unit2_input_pin_map,
  input  wire logic                   comparator_a_result,
  input  wire logic                   comparator_b_result,
  input  wire logic                   pin_change_event,
  output var  ccpu_pkg::ccpu_pin_t    unit1_pin,
  output var  ccpu_pkg::ccpu_pin_t    unit2_pin,
  output var  logic [2:0]             timer_clear,
  output var  logic [1:0]             unit_irq_flag,
  output var  logic [9:0]             unit1_pulse_width_value,
  output var  logic [9:0]             unit2_pulse_width_value,
  output var  logic [7:0]             timer_select_value
);
  import ccpu_pkg::*;

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Reserved selector code gives a zero count and so no match
  function automatic logic [15:0] pick_count(
    input logic [1:0]  sel,
    input logic [15:0] c1,
    input logic [15:0] c3,
    input logic [15:0] c5
  );
    case (sel)
      2'h1:    pick_count = c1;
      2'h2:    pick_count = c3;
      2'h3:    pick_count = c5;
      default: pick_count = 16'h0000;
    endcase
  endfunction : pick_count

  function automatic logic is_unit_addr(input logic [7:0] a);
    is_unit_addr = (a[7:3] == `CCPU_A_UNIT_HI);
  endfunction : is_unit_addr

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m >= `CCPU_M_CAP_ANY) && (m <= `CCPU_M_CAP_16);
  endfunction : is_capture

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'h3);
  endfunction : is_pwm

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m != `CCPU_M_OFF) && !is_capture(m) && !is_pwm(m);
  endfunction : is_compare

  function automatic logic clears_timer(input logic [3:0] m);
    clears_timer = (m == `CCPU_M_TGL_CLR) || (m == `CCPU_M_PLS_CLR);
  endfunction : clears_timer

  // Field split of the data pair follows the alignment bit
  function automatic logic [9:0] pulse_width(
    input logic       left,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    if (left) begin
      pulse_width = {hi, lo[7:6]};
    end else begin
      pulse_width = {hi[1:0], lo};
    end
  endfunction : pulse_width

  // ==========================================================
  // State
  // ==========================================================
  ccpu_state_t s_reg;
  ccpu_state_t s_next;

  always_comb begin
    logic        pin_raw;
    logic [1:0]  sel;
    logic [15:0] count;
    logic [3:0]  mode;
    logic        active;
    logic        src;
    logic        rise;
    logic        fall;
    logic        cap_evt;
    logic        match;
    logic        hit;
    logic        unit_hit;
    logic [7:0]  ofs;
    pin_raw  = 1'b0;
    sel      = 2'h0;
    count    = 16'h0000;
    mode     = 4'h0;
    active   = 1'b0;
    src      = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    cap_evt  = 1'b0;
    match    = 1'b0;
    hit      = 1'b0;
    unit_hit = 1'b0;
    ofs      = bus_req.addr;
    s_next   = s_reg;

    // ========================================================
    // Shared synchronisers and defaults
    // ========================================================
    // Comparator results are asynchronous: two flops before use
    s_next.cmpa_s1 = comparator_a_result;
    s_next.cmpa_s2 = s_reg.cmpa_s1;
    s_next.cmpb_s1 = comparator_b_result;
    s_next.cmpb_s2 = s_reg.cmpb_s1;
    s_next.tclr    = 3'h0;
    s_next.rdata   = 8'h00;

    // ========================================================
    // Register read, answered in the next cycle
    // ========================================================
    // Read data stand one cycle and are zero otherwise
    if (bus_req.rd) begin
      if (is_unit_addr(ofs)) begin
        case (ofs[1:0])
          `CCPU_R_CTRL: begin
            s_next.rdata = s_reg.unit[ofs[2]].ctrl;
            s_next.rdata[`CCPU_B_OUT] = s_reg.unit[ofs[2]].out;
          end
          `CCPU_R_CAPSEL: begin
            s_next.rdata = {6'h00, s_reg.unit[ofs[2]].capsel};
          end
          `CCPU_R_DATA_LO: begin
            s_next.rdata = s_reg.unit[ofs[2]].data_lo;
          end
          default: begin
            s_next.rdata = s_reg.unit[ofs[2]].data_hi;
          end
        endcase
      end else if (ofs == `CCPU_A_TMRSEL) begin
        s_next.rdata = s_reg.tmrsel;
      end else if (ofs == `CCPU_A_FLAGS) begin
        s_next.rdata = {6'h00, s_reg.unit[1].irq, s_reg.unit[0].irq};
      end else if (ofs == `CCPU_A_ODRAIN) begin
        s_next.rdata = {6'h00, s_reg.unit[1].odrain,
                        s_reg.unit[0].odrain};
      end else begin
        s_next.rdata = 8'h00;
      end
    end

    // ========================================================
    // Register write; events below take precedence
    // ========================================================
    if (bus_req.wr) begin
      if (is_unit_addr(ofs)) begin
        case (ofs[1:0])
          `CCPU_R_CTRL: begin
            s_next.unit[ofs[2]].ctrl = bus_req.wdata & `CCPU_CTRL_WMASK;
          end
          `CCPU_R_CAPSEL: begin
            s_next.unit[ofs[2]].capsel = bus_req.wdata[1:0];
          end
          `CCPU_R_DATA_LO: begin
            s_next.unit[ofs[2]].data_lo = bus_req.wdata;
          end
          default: begin
            s_next.unit[ofs[2]].data_hi = bus_req.wdata;
          end
        endcase
      end else if (ofs == `CCPU_A_TMRSEL) begin
        // Upper fields only steer PWM channels outside this block
        s_next.tmrsel = bus_req.wdata;
      end else if (ofs == `CCPU_A_FLAGS) begin
        // Write one to clear a flag
        s_next.unit[0].irq = s_reg.unit[0].irq & ~bus_req.wdata[0];
        s_next.unit[1].irq = s_reg.unit[1].irq & ~bus_req.wdata[1];
      end else if (ofs == `CCPU_A_ODRAIN) begin
        s_next.unit[0].odrain = bus_req.wdata[0];
        s_next.unit[1].odrain = bus_req.wdata[1];
      end
    end

    // ========================================================
    // Per-unit behaviour; both units run side by side
    // ========================================================
    for (int u = 0; u < 2; u++) begin
      pin_raw = (u == 0) ? unit1_input_pin_map : unit2_input_pin_map;
      s_next.unit[u].pin_s1 = pin_raw;
      s_next.unit[u].pin_s2 = s_reg.unit[u].pin_s1;

      sel    = s_reg.tmrsel[2*u +: 2];
      count  = pick_count(sel, timer_one_count, timer_three_count,
                          timer_five_count);
      mode   = s_reg.unit[u].ctrl[3:0];
      active = s_reg.unit[u].ctrl[`CCPU_B_EN] &&
               (mode != `CCPU_M_OFF);

      // Capture source selection
      case (s_reg.unit[u].capsel)
        `CCPU_SRC_PIN:  src = s_reg.unit[u].pin_s2;
        `CCPU_SRC_CMPA: src = s_reg.cmpa_s2;
        `CCPU_SRC_CMPB: src = s_reg.cmpb_s2;
        // Pin-change event is on this clock, so it is used directly
        default:        src = pin_change_event;
      endcase
      s_next.unit[u].src_prev = src;
      rise = src && !s_reg.unit[u].src_prev;
      fall = !src && s_reg.unit[u].src_prev;

      // Capture event and prescaler
      // A 4/16 switch keeps the count; clear the control first
      cap_evt = 1'b0;
      if (!active || !is_capture(mode)) begin
        s_next.unit[u].pre_cnt = 4'h0;
      end else begin
        case (mode)
          `CCPU_M_CAP_ANY:  cap_evt = rise || fall;
          `CCPU_M_CAP_FALL: cap_evt = fall;
          `CCPU_M_CAP_RISE: cap_evt = rise;
          `CCPU_M_CAP_4: begin
            if (rise) begin
              cap_evt = (s_reg.unit[u].pre_cnt >= `CCPU_PRE_4_LAST);
              s_next.unit[u].pre_cnt = cap_evt ? 4'h0 :
                                       s_reg.unit[u].pre_cnt + 4'h1;
            end
          end
          `CCPU_M_CAP_16: begin
            if (rise) begin
              cap_evt = (s_reg.unit[u].pre_cnt == `CCPU_PRE_16_LAST);
              s_next.unit[u].pre_cnt = s_reg.unit[u].pre_cnt + 4'h1;
            end
          end
          default: cap_evt = 1'b0;
        endcase
      end
      if (cap_evt) begin
        s_next.unit[u].data_lo = count[7:0];
        s_next.unit[u].data_hi = count[15:8];
      end

      // Compare match, acted on in its first cycle only
      // so a stopped timer on the match value does not retrigger
      match = (sel != 2'h0) && active && is_compare(mode) &&
              (count == {s_reg.unit[u].data_hi,
                         s_reg.unit[u].data_lo});
      s_next.unit[u].match_prev = match;
      hit = match && !s_reg.unit[u].match_prev;
      unit_hit = hit;
      case (mode)
        `CCPU_M_TGL_CLR,
        `CCPU_M_TGL: begin
          if (hit) begin
            s_next.unit[u].out = !s_reg.unit[u].out;
          end
        end
        `CCPU_M_SET: begin
          if (hit) begin
            s_next.unit[u].out = 1'b1;
          end
        end
        `CCPU_M_CLR: begin
          if (hit) begin
            s_next.unit[u].out = 1'b0;
          end
        end
        `CCPU_M_PLS,
        `CCPU_M_PLS_CLR: begin
          s_next.unit[u].out = hit;
        end
        default: begin
          s_next.unit[u].out = 1'b0;
        end
      endcase
      if (hit && clears_timer(mode)) begin
        s_next.tclr[sel - 2'h1] = 1'b1;
      end

      // Flag set wins over a software clear
      if (cap_evt || unit_hit) begin
        s_next.unit[u].irq = 1'b1;
      end

      // Disabled or cleared control forces the latch low
      if (!s_next.unit[u].ctrl[`CCPU_B_EN] ||
          (s_next.unit[u].ctrl[3:0] == `CCPU_M_OFF)) begin
        s_next.unit[u].out = 1'b0;
      end

      // PWM width value for the waveform generator
      if (active && is_pwm(mode)) begin
        s_next.unit[u].width = pulse_width(
          s_reg.unit[u].ctrl[`CCPU_B_ALIGN],
          s_reg.unit[u].data_hi, s_reg.unit[u].data_lo);
      end else begin
        s_next.unit[u].width = 10'h000;
      end

      // Pin drive: push-pull or open drain in output modes
      if (active && !is_capture(mode)) begin
        // Open drain only pulls low; a pull-up makes the high level
        if (s_reg.unit[u].odrain) begin
          s_next.unit[u].pin.level = 1'b0;
          s_next.unit[u].pin.oe    = !s_next.unit[u].out;
        end else begin
          s_next.unit[u].pin.level = s_next.unit[u].out;
          s_next.unit[u].pin.oe    = 1'b1;
        end
      end else begin
        s_next.unit[u].pin.level = 1'b0;
        s_next.unit[u].pin.oe    = 1'b0;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg        <= '0;
      s_reg.tmrsel <= `CCPU_TMRSEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  // ==========================================================
  assign bus_rdata               = s_reg.rdata;
  assign unit1_pin               = s_reg.unit[0].pin;
  assign unit2_pin               = s_reg.unit[1].pin;
  assign timer_clear             = s_reg.tclr;
  assign unit_irq_flag           = {s_reg.unit[1].irq, s_reg.unit[0].irq};
  assign unit1_pulse_width_value = s_reg.unit[0].width;
  assign unit2_pulse_width_value = s_reg.unit[1].width;
  assign timer_select_value      = s_reg.tmrsel;
endmodule : ccpu_top
`default_nettype wire

// ---- ccpu_timer_model.sv ----
// Far-side timer counters watched by the capture/compare units
`timescale 1ns/1ps
`default_nettype none
module ccpu_timer_model (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [15:0]      load_val,
  input  wire logic [2:0]       timer_clear,
  output var  logic [2:0][15:0] cnt
);
  always_ff @(posedge clk_sys or posedge reset) begin
    for (int i = 0; i < 3; i++) begin
      if (reset) cnt[i] <= 16'h0000;
      else if (timer_clear[i]) cnt[i] <= 16'h0000;
      else if (load) cnt[i] <= load_val;
      else if (run) cnt[i] <= cnt[i] + 16'h0001;
    end
  end
endmodule : ccpu_timer_model
`default_nettype wire

// ---- ccpu_top_sva.sv ----
// Port-level checker for the capture/compare/PWM block
`timescale 1ns/1ps
`default_nettype none
module ccpu_top_chk (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire ccpu_pkg::ccpu_bus_req_t bus_req,
  input wire logic [7:0]              bus_rdata,
  input wire ccpu_pkg::ccpu_pin_t     unit1_pin,
  input wire logic [2:0]              timer_clear,
  input wire logic [1:0]              unit_irq_flag,
  input wire logic [7:0]              timer_select_value
);
  import ccpu_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========
  // Register port
  rdata_idle_a: assert property (
    !$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero when idle");
  tmrsel_read_a: assert property (
    $past(bus_req.rd && bus_req.addr == 8'h08) |->
    bus_rdata == timer_select_value) else $error("timer select readback");
  tmrsel_write_a: assert property (
    bus_req.wr && bus_req.addr == 8'h08 |=>
    timer_select_value == $past(bus_req.wdata)) else $error("timer select");
  unmapped_zero_a: assert property (
    $past(bus_req.rd && bus_req.addr > 8'h0A) |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_bit6_a: assert property (
    $past(bus_req.rd && (bus_req.addr == 8'h00 || bus_req.addr == 8'h04))
    |-> !bus_rdata[6]) else $error("control bit 6 not zero");
  // ==========
  // Compare outputs and flags
  clear_once_a: assert property (
    timer_clear[0] |=> !timer_clear[0]) else $error("clear pulse too long");
  clear_irq_a: assert property (
    |timer_clear |-> |unit_irq_flag) else $error("clear without flag");
  flag_clear_a: assert property (
    $fell(unit_irq_flag[0]) |->
    $past(bus_req.wr && bus_req.addr == 8'h09 && bus_req.wdata[0]))
    else $error("flag dropped without software clear");
  pin_level_a: assert property (
    unit1_pin.level |-> unit1_pin.oe) else $error("pin high but not driven");
  cover property (timer_clear[1]);
  cover property ($rose(unit_irq_flag[0]));
  cover property (bus_req.wr && bus_req.addr == 8'h09);
endmodule : ccpu_top_chk
bind ccpu_top ccpu_top_chk u_chk (.clk_sys(clk_sys), .reset(reset),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .unit1_pin(unit1_pin),
  .timer_clear(timer_clear), .unit_irq_flag(unit_irq_flag),
  .timer_select_value(timer_select_value));
`default_nettype wire

// ---- capture_compare_pwm_unit_tb.sv ----
// Self-checking testbench for the capture/compare/PWM block
`timescale 1ns/1ps
`default_nettype none
module capture_compare_pwm_unit_tb;
  import ccpu_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  ccpu_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic [2:0][15:0] cnt;
  logic [3:0] src_v = 4'h0;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0000;
  logic [15:0] d;
  ccpu_pin_t p1, p2;
  logic [2:0] tclr;
  logic [1:0] flg;
  logic [9:0] pw1;
  logic [9:0] pw2;
  logic [7:0] tsv;
  logic [7:0] q[$];
  logic rd_q = 1'b0;
  logic [3:0] cm [6] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
  logic ce [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int n_errors = 0;
  int check_count = 0;

  ccpu_timer_model tmr (.clk_sys(clk_sys), .reset(reset), .run(run),
    .load(load), .load_val(load_val), .timer_clear(tclr), .cnt(cnt));
  ccpu_top dut (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .timer_one_count(cnt[0]),
    .timer_three_count(cnt[1]), .timer_five_count(cnt[2]),
    .unit1_input_pin_map(src_v[0]), .unit2_input_pin_map(src_v[0]),
    .comparator_a_result(src_v[1]), .comparator_b_result(src_v[2]),
    .pin_change_event(src_v[3]), .unit1_pin(p1), .unit2_pin(p2),
    .timer_clear(tclr), .unit_irq_flag(flg),
    .unit1_pulse_width_value(pw1), .unit2_pulse_width_value(pw2),
    .timer_select_value(tsv));

  initial forever #5 clk_sys = ~clk_sys;

  // ==========
  // Checking and bus tasks
  task conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask : chk

  task bus(input logic [7:0] a, input logic [7:0] dv, input logic w);
    @(posedge clk_sys);
    bus_req <= '{a, dv, w, !w};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] dv);
    bus(a, dv, 1'b1);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(a, 8'h00, 1'b0);
  endtask : rd

  always @(posedge clk_sys) begin
    if (rd_q) chk(bus_rdata, q.pop_front(), "read data");
    rd_q <= bus_req.rd;
  end

  task wait_flag(input logic u);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (flg[u] === 1'b1) break;
    end
    if (i == 400) begin
      n_errors++;
      conclude();
    end
  endtask : wait_flag

  task load_timer(input logic [15:0] v);
    @(posedge clk_sys);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask : load_timer

  // ==========
  // Compare and capture scenarios
  task cmp(input logic u, input logic [3:0] m, input logic e);
    logic c;
    c = (m == 4'h1 || m == 4'hB);
    load_timer(16'h0000);
    wr({5'h00, u, 2'b00}, {4'h8, m});
    run <= 1'b1;
    wait_flag(u);
    run <= 1'b0;
    chk(u ? p2.level : p1.level, e, "pin level");
    chk(tclr, c ? (u ? 3'b010 : 3'b001) : 3'b000, "timer clear");
    rd({5'h00, u, 2'b00}, {2'b10, (m[3:1] != 3'b101) & e, 1'b0, m});
    rd(8'h09, u ? 8'h02 : 8'h01);
    wr(8'h09, u ? 8'h02 : 8'h01);
    rd(8'h09, 8'h00);
  endtask : cmp

  task cap(input logic [3:0] m);
    logic [15:0] v;
    int need;
    v = 16'($urandom);
    need = (m == 4'h6) ? 4 : (m == 4'h7) ? 16 : 1;
    wr(8'h01, {6'h00, m[1:0]});
    load_timer(v);
    wr(8'h00, {4'h8, m});
    wr(8'h09, 8'h01);
    for (int k = 1; k <= need; k++) begin
      src_v[m[1:0]] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      src_v[m[1:0]] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk(flg[0], k == need, "capture flag");
    end
    rd(8'h02, v[7:0]);
    rd(8'h03, v[15:8]);
    wr(8'h00, 8'h00);
  endtask : cap

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end

  // ==========
  // Main sequence
  initial begin
    void'($urandom(79));
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h08, 8'h55);
    rd(8'h00, 8'h00);
    rd(8'h0F, 8'h00);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h03);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h9F);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'h20);
    wr(8'h03, 8'h00);
    rd(8'h02, 8'h20);
    foreach (cm[i]) cmp(1'b0, cm[i], ce[i]);
    cmp(1'b0, 4'h8, 1'b1);
    wr(8'h0A, 8'h01);
    rd(8'h0A, 8'h01);
    @(posedge clk_sys);
    chk(p1, 2'b00, "open drain pin");
    wr(8'h0A, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(p1, 2'b11, "push pull pin");
    wr(8'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(p1, 2'b00, "disabled pin");
    rd(8'h00, 8'h00);
    wr(8'h08, 8'h59);
    @(posedge clk_sys);
    chk(tsv, 8'h59, "timer select");
    wr(8'h06, 8'h20);
    wr(8'h07, 8'h00);
    cmp(1'b1, 4'h1, 1'b1);
    wr(8'h04, 8'h00);
    for (int m = 3; m <= 7; m++) cap(4'(m));
    for (int a = 0; a < 2; a++) begin
      d = 16'($urandom);
      wr(8'h02, d[7:0]);
      wr(8'h03, d[15:8]);
      wr(8'h00, 8'h8C | 8'(a * 17));
      repeat (2) @(posedge clk_sys);
      chk(pw1, a ? {d[15:8], d[7:6]} : {d[9:8], d[7:0]}, "width");
    end
    wr(8'h06, d[7:0]);
    wr(8'h07, d[15:8]);
    wr(8'h04, 8'h9F);
    repeat (2) @(posedge clk_sys);
    chk(pw2, {d[15:8], d[7:6]}, "width two");
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(pw1, 10'h000, "width off");
    chk(pw2, 10'h000, "width two off");
    repeat (3) @(posedge clk_sys);
    conclude();
  end
endmodule : capture_compare_pwm_unit_tb
`default_nettype wire
